// ---- rtl/kds_sequencer.sv ----
/*
 keypad dialing sequencer: keys in, serial key codes and line break out,
 configuration and speed memories over ahb-lite.
 assumes keys arrive as one-cycle pulses synchronous to sys_clk.
*/
// Chosen here: the AHB-Lite interface to the registers and the address map.
// What this block does
// - each dialed key shifts 4-bit code msb first
// - data bit valid at serial clock falling edge
// - digits binary, 0=1010, star, hash, flash, pause codes
// - locked first key disables all output for call
// - two lock inputs choose lock mode
// - pulse star waits then switches to tone
// - hash dials only in tone mode
// - copy key saves number, later redials it
// - copy key ignored while transmitting
// - memorize key ignored while transmitting
// - flash breaks line then post-flash pause
// - pause key suspends output for pause time
// - redial/pause: redial if first, else pause
// - two-touch key plus digit dials location
// - one-touch keys dial stored number directly
// - redial memory 32 digits, overflow disables redial
// - redial leaves redial and save memories unchanged
// - again after digits: break, pause, redial
// - over 32 digits: no one-key redial, line high
// - over 32 digits: save skipped, memory kept
// - copy loads dialed digits into save memory
// - pulse star: pulses, pause, then tones
// - flash between digits: redial keeps earlier digits
// - flash first: redial memory unchanged
// - pause and switch wait 3.6s, or 2s/1s
// - flash time 600, 98 or 300 ms
`timescale 1ns/100ps
`include "kds_defs.svh"
module kds_sequencer #(
   parameter int TICK_CYCLES = `KDS_CLK_HZ / `KDS_MS_PER_S
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire kds_pkg::kds_key_s key,
   input wire logic off_hook,
   output logic line_break_out,
   output logic digit_data,
   output logic digit_clk
);
   // ************************************************
   // bus slave
   // ************************************************
   function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
      reg_hit = (a == off);
   endfunction : reg_hit

   kds_pkg::kds_cfg_s cfg;
   kds_pkg::kds_stat_s stat;
   logic wr_pend;
   logic [7:0] wr_addr;
   wire ahb_take = hsel && hready && htrans[1];
   wire wr_ctrl = wr_pend && reg_hit(wr_addr, `KDS_OFF_CTRL);
   wire wr_mem = wr_pend && reg_hit(wr_addr, `KDS_OFF_MEMWR);
   wire kds_pkg::kds_memwr_s memwr = kds_pkg::kds_memwr_s'(hwdata[12:0]);
   wire [31:0] rd_val = reg_hit(haddr[7:0], `KDS_OFF_CTRL) ? {25'h0, cfg} :
                        reg_hit(haddr[7:0], `KDS_OFF_STAT) ? {16'h0, stat} : 32'h0;

   // zero-wait slave: read data is caught at the address phase
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0;
         wr_pend <= 1'b0;
         wr_addr <= 8'h0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend <= ahb_take && hwrite;
         wr_addr <= haddr[7:0];
         if (ahb_take && !hwrite) begin
            hrdata <= rd_val;
         end
      end
   end

   // configuration register, steers lock, flash and pause timing
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cfg <= kds_pkg::kds_cfg_s'(`KDS_CTRL_RST);
      end else if (wr_ctrl) begin
         cfg <= kds_pkg::kds_cfg_s'(hwdata[6:0]);
      end
   end

   // ************************************************
   // call state and key decode
   // ************************************************
   kds_pkg::kds_state_e state;
   logic off_hook_q, first_key, locked, tone, rec_fresh, rec_stop, over32;
   logic saved_call, tt_armed, playing, brk_onekey;
   logic [5:0] rm_len, sam_len, pidx, plen;
   logic [3:0] rm_mem [0:31];
   logic [3:0] sam_mem [0:31];
   logic [3:0] spd_mem [0:`KDS_SPD_LOCS-1][0:`KDS_SPD_DIGITS-1];
   logic [4:0] spd_len [0:`KDS_SPD_LOCS-1];
   kds_pkg::kds_src_e src;
   logic [3:0] src_loc, shreg, elem;
   logic [11:0] timer;
   logic [15:0] ms_div;
   logic [4:0] ser_div;
   logic [2:0] ser_ph;

   function automatic logic [3:0] digit_bcd(input kds_pkg::kds_key_e c);
      case (c)
         kds_pkg::KC_D0: digit_bcd = `KDS_BCD_ZERO;
         kds_pkg::KC_STAR: digit_bcd = `KDS_BCD_STAR;
         kds_pkg::KC_HASH: digit_bcd = `KDS_BCD_HASH;
         kds_pkg::KC_FLASH: digit_bcd = `KDS_BCD_FLASH;
         kds_pkg::KC_PAUSE, kds_pkg::KC_RPAUSE: digit_bcd = `KDS_BCD_PAUSE;
         default: digit_bcd = c[3:0];
      endcase
   endfunction : digit_bcd

   wire hook_edge = off_hook != off_hook_q;
   wire is_digit = key.code <= kds_pkg::KC_D9;
   wire k_star = key.code == kds_pkg::KC_STAR;
   wire k_hash = key.code == kds_pkg::KC_HASH;
   wire k_flash = key.code == kds_pkg::KC_FLASH;
   wire k_pause = key.code == kds_pkg::KC_PAUSE;
   wire k_again = key.code == kds_pkg::KC_AGAIN;
   wire k_rpause = key.code == kds_pkg::KC_RPAUSE;
   wire k_copy = key.code == kds_pkg::KC_COPY;
   wire k_auto = key.code == kds_pkg::KC_AUTO;
   wire k_em = key.code >= kds_pkg::KC_EM1;
   wire [3:0] kbcd = digit_bcd(key.code);
   // keypad mode 00 needs stored lock numbers, not kept here
   wire lock_mode_hit = (cfg.lock_option_b && !cfg.lock_option_a && key.code == kds_pkg::KC_D0) ||
                        (cfg.lock_option_a && !cfg.lock_option_b &&
                         (key.code == kds_pkg::KC_D0 || key.code == kds_pkg::KC_D9)) ||
                        (cfg.lock_option_a && cfg.lock_option_b);
   wire key_ok = key.valid && off_hook && !locked && !hook_edge &&
                 state == kds_pkg::S_IDLE && !playing;
   wire lock_hit = key_ok && cfg.lock_en && first_key && lock_mode_hit;
   wire key_take = key_ok && !lock_hit;
   // keys that start an output element at once
   wire key_emit = (is_digit && !tt_armed) || k_star || k_hash || k_flash || k_pause ||
                   (k_rpause && !first_key);
   wire key_go = key_take && key_emit;
   wire record_key = key_go && !k_flash && !(k_hash && !tone) && !rec_stop;
   wire play_rm_key = key_take && (k_again || k_rpause) && first_key && !over32;
   wire onekey_key = key_take && k_again && !first_key && !over32 && rm_len != '0;
   wire copy_play = key_take && k_copy && (first_key || saved_call);
   wire copy_save = key_take && k_copy && !first_key && !saved_call && !rec_fresh && !over32;
   wire tt_play = key_take && is_digit && tt_armed;
   wire em_play = key_take && k_em;

   // ************************************************
   // timing selection and dividers
   // ************************************************
   wire ms_tick = ms_div == 16'(TICK_CYCLES - 1);
   wire ser_tick = ser_div == (`KDS_SER_HALF - 5'h1);
   wire wait_done = ms_tick && timer == '0;
   wire [11:0] t_pause = cfg.pause_duration_option ? `KDS_T_PAUSE_SHORT : `KDS_T_PAUSE_LONG;
   wire [11:0] t_tpt = cfg.pause_duration_option ? `KDS_T_TPT_SHORT : `KDS_T_TPT_LONG;
   wire [11:0] t_flash = !cfg.flash_option_a ? `KDS_T_FLASH_600 :
                         cfg.flash_option_b ? `KDS_T_FLASH_300 : `KDS_T_FLASH_98;
   wire star_switch = elem == `KDS_BCD_STAR && !tone;
   wire is_flash = elem == `KDS_BCD_FLASH;
   wire kds_pkg::kds_state_e post_state = is_flash ? kds_pkg::S_BREAK :
                        (elem == `KDS_BCD_PAUSE || star_switch) ? kds_pkg::S_WAIT : kds_pkg::S_IDLE;
   wire [11:0] post_time = is_flash ? t_flash : elem == `KDS_BCD_PAUSE ? t_pause : t_tpt;
   wire onekey_fire = state == kds_pkg::S_WAIT && wait_done && brk_onekey;

   // ************************************************
   // playback source and next element
   // ************************************************
   wire play_go = playing && state == kds_pkg::S_IDLE && pidx < plen;
   wire [3:0] play_code = src == kds_pkg::SRC_RM ? rm_mem[pidx[4:0]] :
                          src == kds_pkg::SRC_SAM ? sam_mem[pidx[4:0]] : spd_mem[src_loc][pidx[4:0]];
   wire go = play_go || key_go;
   wire [3:0] go_code = play_go ? play_code : kbcd;
   wire skip_hash = go_code == `KDS_BCD_HASH && !tone;
   wire [3:0] em_loc = 4'(key.code - kds_pkg::KC_EM1) + `KDS_EM_BASE;

   // ms enable and serial bit enable
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ms_div <= 16'h0;
         ser_div <= 5'h0;
      end else begin
         ms_div <= ms_tick ? 16'h0 : ms_div + 16'h1;
         ser_div <= (state != kds_pkg::S_FRAME || ser_tick) ? 5'h0 : ser_div + 5'h1;
      end
   end

   // call flags; a hook change starts a fresh call
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         off_hook_q <= 1'b0;
         first_key <= 1'b1;
         locked <= 1'b0;
         tone <= 1'b0;
         saved_call <= 1'b0;
         tt_armed <= 1'b0;
      end else begin
         off_hook_q <= off_hook;
         if (hook_edge) begin
            first_key <= 1'b1;
            locked <= 1'b0;
            tone <= cfg.tone_default;
            saved_call <= 1'b0;
            tt_armed <= 1'b0;
         end else begin
            if (lock_hit) begin
               locked <= 1'b1;
            end
            if (key_take) begin
               first_key <= 1'b0;
               tt_armed <= k_auto;
            end
            if (copy_save) begin
               saved_call <= 1'b1;
            end
            if (state == kds_pkg::S_WAIT && wait_done && star_switch) begin
               tone <= 1'b1;
            end
         end
      end
   end

   // redial memory recording; the first recorded key of a call clears the old number
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rm_len <= 6'h0;
         over32 <= 1'b0;
         rec_fresh <= 1'b1;
         rec_stop <= 1'b0;
      end else if (hook_edge) begin
         rec_fresh <= 1'b1;
         rec_stop <= 1'b0;
      end else begin
         if (key_take && k_flash) begin
            rec_stop <= 1'b1;
         end
         if (record_key && rec_fresh) begin
            rm_len <= 6'h1;
            over32 <= 1'b0;
            rec_fresh <= 1'b0;
         end else if (record_key && rm_len < `KDS_RM_DEPTH) begin
            rm_len <= rm_len + 6'h1;
         end else if (record_key) begin
            over32 <= 1'b1;
         end
      end
   end

   // memory arrays: redial, save and speed locations
   wire [4:0] rm_wr_idx = rec_fresh ? 5'h0 : rm_len[4:0];
   always_ff @(posedge sys_clk) begin
      if (record_key && (rec_fresh || rm_len < `KDS_RM_DEPTH)) begin
         rm_mem[rm_wr_idx] <= kbcd;
      end
      if (copy_save) begin
         sam_mem <= rm_mem;
      end
      if (wr_mem && memwr.loc < 4'(`KDS_SPD_LOCS) && memwr.idx < 5'(`KDS_SPD_DIGITS)) begin
         spd_mem[memwr.loc][memwr.idx] <= memwr.code;
      end
   end

   // lengths of the save and speed memories
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sam_len <= 6'h0;
         for (int i = 0; i < `KDS_SPD_LOCS; i++) begin
            spd_len[i] <= 5'h0;
         end
      end else begin
         if (copy_save) begin
            sam_len <= rm_len;
         end
         if (wr_mem && memwr.loc < 4'(`KDS_SPD_LOCS) && memwr.idx < 5'(`KDS_SPD_DIGITS)) begin
            spd_len[memwr.loc] <= memwr.idx + 5'h1;
         end
      end
   end

   // playback walker; redial paths read memories and never write them
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         playing <= 1'b0;
         src <= kds_pkg::SRC_RM;
         src_loc <= 4'h0;
         pidx <= 6'h0;
         plen <= 6'h0;
      end else if (hook_edge) begin
         playing <= 1'b0;
      end else if (play_rm_key || onekey_fire) begin
         playing <= 1'b1;
         src <= kds_pkg::SRC_RM;
         pidx <= 6'h0;
         plen <= rm_len;
      end else if (copy_play) begin
         playing <= 1'b1;
         src <= kds_pkg::SRC_SAM;
         pidx <= 6'h0;
         plen <= sam_len;
      end else if (tt_play || em_play) begin
         playing <= 1'b1;
         src <= kds_pkg::SRC_SPD;
         src_loc <= tt_play ? key.code[3:0] : em_loc;
         pidx <= 6'h0;
         plen <= {1'b0, spd_len[tt_play ? key.code[3:0] : em_loc]};
      end else if (play_go) begin
         pidx <= pidx + 6'h1;
      end else if (playing && state == kds_pkg::S_IDLE) begin
         playing <= 1'b0;
      end
   end

   // one-key break marker, read when the break ends
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         brk_onekey <= 1'b0;
      end else if (onekey_key) begin
         brk_onekey <= 1'b1;
      end else if (state == kds_pkg::S_IDLE) begin
         brk_onekey <= 1'b0;
      end
   end

   // ************************************************
   // output sequencer
   // ************************************************
   // frame is four bits, two half periods each; clock rests low
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state <= kds_pkg::S_IDLE;
         shreg <= 4'h0;
         elem <= 4'h0;
         ser_ph <= 3'h0;
         timer <= 12'h0;
         digit_clk <= 1'b0;
         digit_data <= 1'b0;
      end else if (hook_edge) begin
         state <= kds_pkg::S_IDLE;
         digit_clk <= 1'b0;
      end else begin
         case (state)
            kds_pkg::S_IDLE: begin
               if (go && !skip_hash) begin
                  state <= kds_pkg::S_FRAME;
                  shreg <= go_code;
                  elem <= go_code;
                  ser_ph <= 3'h0;
                  digit_clk <= 1'b1;
                  digit_data <= go_code[3];
               end else if (onekey_key) begin
                  state <= kds_pkg::S_BREAK;
                  timer <= `KDS_T_ONEKEY_BRK;
               end
            end
            kds_pkg::S_FRAME: begin
               if (ser_tick && ser_ph == `KDS_SER_LAST) begin
                  state <= post_state;
                  timer <= post_time;
               end else if (ser_tick) begin
                  ser_ph <= ser_ph + 3'h1;
                  digit_clk <= ser_ph[0];
                  if (ser_ph[0]) begin
                     shreg <= {shreg[2:0], 1'b0};
                     digit_data <= shreg[2];
                  end
               end
            end
            kds_pkg::S_BREAK: begin
               if (wait_done) begin
                  state <= kds_pkg::S_WAIT;
                  timer <= brk_onekey ? `KDS_T_ONEKEY_RP : `KDS_T_POST_FLASH;
               end else if (ms_tick) begin
                  timer <= timer - 12'h1;
               end
            end
            kds_pkg::S_WAIT: begin
               if (wait_done) begin
                  state <= kds_pkg::S_IDLE;
               end else if (ms_tick) begin
                  timer <= timer - 12'h1;
               end
            end
            default: begin
               state <= kds_pkg::S_IDLE;
            end
         endcase
      end
   end

   // line goes low only during a break
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         line_break_out <= 1'b1;
      end else begin
         line_break_out <= state != kds_pkg::S_BREAK;
      end
   end

   // status word
   assign stat = '{sam_len: sam_len, rm_len: rm_len, over32: over32, locked: locked,
                   tone: tone, busy: state != kds_pkg::S_IDLE || playing};

   // ************************************************
   // checks
   // ************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   // falls of the serial clock seen in the current frame
   logic clk_q;
   logic [2:0] fall_cnt;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         clk_q <= 1'b0;
         fall_cnt <= 3'h0;
      end else begin
         clk_q <= digit_clk;
         if (state == kds_pkg::S_IDLE) begin
            fall_cnt <= 3'h0;
         end else if (clk_q && !digit_clk) begin
            fall_cnt <= fall_cnt + 3'h1;
         end
      end
   end

   frame_bits_a: assert property ($past(state == kds_pkg::S_FRAME) && state != kds_pkg::S_FRAME
      && !$past(hook_edge) |-> fall_cnt == 3'h4) else $error("frame without four clock falls");
   data_stable_a: assert property ($fell(digit_clk) |-> $stable(digit_data))
      else $error("data moved at clock fall");
   zero_code_a: assert property (key_go && !play_go && key.code == kds_pkg::KC_D0
      |=> state == kds_pkg::S_FRAME && shreg == `KDS_BCD_ZERO) else $error("bad code for zero");
   lock_quiet_a: assert property (locked |-> state == kds_pkg::S_IDLE && !digit_clk && !playing)
      else $error("output while locked");
   hash_pulse_a: assert property (key_take && k_hash && !tone |=> state == kds_pkg::S_IDLE)
      else $error("hash dialed in pulse mode");
   copy_busy_a: assert property (key.valid && k_copy && state != kds_pkg::S_IDLE
      |=> $stable(sam_len) && !($rose(playing) && src == kds_pkg::SRC_SAM))
      else $error("copy taken while busy");
   break_low_a: assert property ($rose(state == kds_pkg::S_BREAK) |=> !line_break_out)
      else $error("line not broken");
   over_high_a: assert property (key_take && k_again && !first_key && over32
      |=> (line_break_out && state == kds_pkg::S_IDLE) [*3]) else $error("one-key redial over 32");
   tone_switch_a: assert property (state == kds_pkg::S_WAIT && wait_done && star_switch |=> tone)
      else $error("no switch to tone");

   star_pulse_c: cover property (state == kds_pkg::S_WAIT && wait_done && star_switch);
   onekey_c: cover property ($rose(state == kds_pkg::S_BREAK) && brk_onekey);
   copy_save_c: cover property (copy_save);
endmodule : kds_sequencer

// ---- rtl/kds_defs.svh ----
/*
 constants of the keypad dialing sequencer: offsets, codes, times.
 assumes a 50 MHz system clock; times are held in milliseconds.
*/
`ifndef KDS_DEFS_SVH
`define KDS_DEFS_SVH
`define KDS_CLK_HZ 50000000
`define KDS_MS_PER_S 1000
// register byte offsets (low address byte)
`define KDS_OFF_CTRL 8'h00
`define KDS_OFF_STAT 8'h04
`define KDS_OFF_MEMWR 8'h08
`define KDS_CTRL_RST 7'h00
// serial key codes
`define KDS_BCD_ZERO 4'ha
`define KDS_BCD_STAR 4'hd
`define KDS_BCD_HASH 4'hc
`define KDS_BCD_FLASH 4'hb
`define KDS_BCD_PAUSE 4'he
// times in ms: 3600, 2000, 1000, 600, 98, 300, 1500
`define KDS_T_PAUSE_LONG 12'he10
`define KDS_T_PAUSE_SHORT 12'h7d0
`define KDS_T_TPT_LONG 12'he10
`define KDS_T_TPT_SHORT 12'h3e8
`define KDS_T_FLASH_600 12'h258
`define KDS_T_FLASH_98 12'h062
`define KDS_T_FLASH_300 12'h12c
`define KDS_T_POST_FLASH 12'h3e8
`define KDS_T_ONEKEY_BRK 12'h258
`define KDS_T_ONEKEY_RP 12'h5dc
// serial clock half period in cycles, last phase of a frame
`define KDS_SER_HALF 5'h19
`define KDS_SER_LAST 3'h7
// memory sizes
`define KDS_RM_DEPTH 6'h20
`define KDS_SPD_DIGITS 18
`define KDS_SPD_LOCS 13
`define KDS_EM_BASE 4'ha
`endif

// ---- rtl/kds_pkg.sv ----
/*
 types of the keypad dialing sequencer.
 assumes kds_defs.svh for the numbers.
*/
package kds_pkg;
   typedef enum logic [4:0] {
      KC_D0 = 5'h00, KC_D1, KC_D2, KC_D3, KC_D4, KC_D5, KC_D6, KC_D7, KC_D8, KC_D9,
      KC_STAR, KC_HASH, KC_FLASH, KC_PAUSE, KC_AGAIN, KC_RPAUSE, KC_COPY, KC_MEMO,
      KC_AUTO, KC_EM1, KC_EM2, KC_EM3
   } kds_key_e;
   typedef struct packed {
      logic valid;
      kds_key_e code;
   } kds_key_s;
   typedef enum logic [1:0] {
      S_IDLE = 2'b00, S_FRAME = 2'b01, S_WAIT = 2'b11, S_BREAK = 2'b10
   } kds_state_e;
   typedef enum logic [1:0] {SRC_RM = 2'b00, SRC_SAM = 2'b01, SRC_SPD = 2'b10} kds_src_e;
   typedef struct packed {
      logic pause_duration_option;
      logic flash_option_b;
      logic flash_option_a;
      logic lock_option_b;
      logic lock_option_a;
      logic lock_en;
      logic tone_default;
   } kds_cfg_s;
   typedef struct packed {
      logic [5:0] sam_len;
      logic [5:0] rm_len;
      logic over32;
      logic locked;
      logic tone;
      logic busy;
   } kds_stat_s;
   typedef struct packed {
      logic [3:0] loc;
      logic [4:0] idx;
      logic [3:0] code;
   } kds_memwr_s;
endpackage : kds_pkg

// ---- tb/kds_line_rx.sv ----
/*
 line side receiver of serial key codes.
 assumes digit_clk idles low between frames.
*/
`timescale 1ns/100ps
module kds_line_rx (
   input wire logic nrst,
   input wire logic digit_clk,
   input wire logic digit_data,
   output logic [3:0] rx_code,
   output int rx_count
);
   logic [3:0] shift;
   int nbits;
   // falling edge sampling, four bits make one frame
   always @(negedge digit_clk or negedge nrst) begin
      if (!nrst) begin
         nbits = 0;
         rx_count <= 0;
         rx_code <= 4'h0;
      end else begin
         shift = {shift[2:0], digit_data};
         nbits = nbits + 1;
         if (nbits == 4) begin
            nbits = 0;
            rx_code <= shift;
            rx_count <= rx_count + 1;
         end
      end
   end
endmodule : kds_line_rx

// ---- tb/testbench.sv ----
/*
 bench of the keypad dialing sequencer: keys, line, ahb-lite registers.
 assumes a short tick so waits stay brief.
*/
`timescale 1ns/100ps
module testbench;
   logic sys_clk, nrst, hsel, hwrite, off_hook, hreadyout, hresp;
   logic line_break_out, digit_data, digit_clk;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd, st;
   logic [3:0] rx_code, e;
   logic [3:0] q[$];
   kds_pkg::kds_key_s key;
   int rx_count, fail_count, checks_done, seed, n, d;
   kds_sequencer #(.TICK_CYCLES(2)) i_kds_sequencer (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .key(key),
      .off_hook(off_hook), .line_break_out(line_break_out), .digit_data(digit_data),
      .digit_clk(digit_clk));
   kds_line_rx i_kds_line_rx (.nrst(nrst), .digit_clk(digit_clk), .digit_data(digit_data),
      .rx_code(rx_code), .rx_count(rx_count));
   // ****************
   // tasks
   // ****************
   task chk(input string nm, input logic [31:0] ex, input logic [31:0] v);
      checks_done++;
      if (v !== ex) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, ex, v);
      end
   endtask : chk
   // one single transfer; entered just after a rising edge
   task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hsel <= 1'b1;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   // one key pulse, then poll busy so the next key is never dropped
   task press(input kds_pkg::kds_key_e c, input int fr, input logic [3:0] ex);
      int c0;
      c0 = rx_count;
      key <= '{1'b1, c};
      @(posedge sys_clk);
      key <= '{1'b0, kds_pkg::KC_D0};
      repeat (3) @(posedge sys_clk);
      n = 0;
      do begin
         bus(1'b0, 32'h4, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 8000);
      // a wait that never ends counts as a mismatch here
      chk("busy", 32'h0, rd[0]);
      chk("frames", c0 + fr, rx_count);
      if (fr > 0) chk("code", ex, rx_code);
   endtask : press
   task hook(input logic [31:0] cfg);
      bus(1'b1, 32'h0, cfg);
      off_hook <= 1'b0;
      repeat (3) @(posedge sys_clk);
      off_hook <= 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask : hook
   // line must be broken well inside the break time
   task brk;
      repeat (400) @(posedge sys_clk);
      chk("line", 32'h0, line_break_out);
   endtask : brk
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      sys_clk = 0;
      forever #10 sys_clk = ~sys_clk;
   end
   // watchdog well beyond the expected run
   initial begin
      #1500000;
      fail_count++;
      tally_and_finish();
   end
   initial begin
      {nrst, hsel, hwrite, off_hook, htrans, haddr, hwdata, key} = '0;
      {fail_count, checks_done, seed} = {32'd0, 32'd0, 32'd34};
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      hook(32'h1);
      bus(1'b0, 32'h0, 32'h0);
      chk("ctrl", 32'h1, rd);
      bus(1'b0, 32'h10, 32'h0);
      chk("unmapped", 32'h0, rd);
      for (int i = 0; i < 6; i++) begin
         d = $unsigned($random(seed)) % 10;
         e = (d == 0) ? 4'ha : 4'(d);
         q.push_back(e);
         press(kds_pkg::kds_key_e'(5'(d)), 1, e);
      end
      bus(1'b0, 32'h4, 32'h0);
      st = rd;
      chk("rm_len", q.size(), st[9:4]);
      fork
         press(kds_pkg::KC_AGAIN, q.size(), q[$]);
         brk();
      join
      bus(1'b0, 32'h4, 32'h0);
      chk("memories", st[15:4], rd[15:4]);
      press(kds_pkg::KC_RPAUSE, 1, 4'he);
      press(kds_pkg::KC_STAR, 1, 4'hd);
      press(kds_pkg::KC_HASH, 1, 4'hc);
      hook(32'h1);
      bus(1'b0, 32'h4, 32'h0);
      st = rd;
      fork
         press(kds_pkg::KC_FLASH, 1, 4'hb);
         brk();
      join
      bus(1'b0, 32'h4, 32'h0);
      chk("rm_len", st[9:4], rd[9:4]);
      hook(32'h0);
      press(kds_pkg::KC_HASH, 0, 4'h0);
      press(kds_pkg::KC_D5, 1, 4'h5);
      press(kds_pkg::KC_COPY, 0, 4'h0);
      bus(1'b0, 32'h4, 32'h0);
      chk("sam_len", 32'h1, rd[15:10]);
      press(kds_pkg::KC_COPY, 1, 4'h5);
      press(kds_pkg::KC_STAR, 1, 4'hd);
      bus(1'b0, 32'h4, 32'h0);
      chk("tone", 32'h1, rd[1]);
      press(kds_pkg::KC_HASH, 1, 4'hc);
      // overflow call: 33 digits refill the redial memory to 32 and set over32, save memory left alone
      hook(32'h1);
      for (int i = 0; i < 33; i++) begin
         press(kds_pkg::KC_D1, 1, 4'h1);
      end
      press(kds_pkg::KC_AGAIN, 0, 4'h0);
      chk("line", 32'h1, line_break_out);
      press(kds_pkg::KC_COPY, 0, 4'h0);
      bus(1'b0, 32'h4, 32'h0);
      chk("over32", 32'h1, rd[3]);
      chk("rm_len", 32'h20, rd[9:4]);
      chk("sam_len", 32'h1, rd[15:10]);
      hook(32'ha);
      press(kds_pkg::KC_D0, 0, 4'h0);
      press(kds_pkg::KC_D1, 0, 4'h0);
      bus(1'b0, 32'h4, 32'h0);
      chk("locked", 32'h1, rd[2]);
      tally_and_finish();
   end
endmodule : testbench
